// [sbcp_boot.sv]
// Serial boot helper: hex record intake, password check, checksums.
// Assumes bytes from the UART arrive at most every other clock and that
// flash read data is valid one clock after flash_rd and then held.
`timescale 1ns/100ps
`include "sbcp_regs.svh"
module sbcp_boot
    import sbcp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  sbcp_mode_t       mode,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_error,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_data,
    input  wire logic        erase_chip,
    input  wire logic [19:0] erase_lo,
    input  wire logic [19:0] erase_hi,
    input  wire logic [7:0]  flash_rdata,
    output logic             flash_rd,
    output logic      [19:0] flash_addr,
    output logic             wr_valid,
    output logic      [19:0] wr_addr,
    output logic      [7:0]  wr_data,
    output logic      [15:0] sum,
    output logic             sum_done,
    output logic             blank,
    output logic             halted
);

    // ======================================================
    // Whole state of the block
    typedef struct packed {
        sbcp_state_t st;
        sbcp_mode_t  mode;
        logic        blank;
        logic [1:0]  bcnt;
        logic [19:0] cnt_addr;
        logic [19:0] cmp_start;
        logic [7:0]  pwn;
        logic [7:0]  pwi;
        logic [7:0]  prev;
        logic [1:0]  run;
        logic        rd_go;
        logic        second;
        logic        er_load;
        logic [19:0] addr;
        logic [19:0] end_addr;
        logic        flash_rd;
        logic [19:0] flash_addr;
        logic        rd_pend;
        sbcp_field_t fld;
        logic [7:0]  len;
        logic [7:0]  cnt;
        logic [7:0]  rtype;
        logic [15:0] raddr;
        logic [7:0]  csum;
        logic [15:0] ext;
        logic        wr_valid;
        logic [19:0] wr_addr;
        logic [7:0]  wr_data;
        logic [4:0]  idx;
        logic        sum_clr;
        logic        sum_add;
        logic [7:0]  sum_byte;
        logic        done;
        logic        halted;
    } sbcp_boot_t;

    sbcp_boot_t s_r;
    sbcp_boot_t s_nxt;

    // ======================================================
    // Address lies in the lower flash area
    function automatic logic in_main(input logic [19:0] a);
        in_main = (a >= `SBCP_FL_LO_LO) && (a <= `SBCP_FL_LO_HI);
    endfunction : in_main

    // ======================================================
    // Checksum accumulator
    sbcp_sum_acc u_acc (
        .clock    (clock),
        .rst_n    (rst_n),
        .clear    (s_r.sum_clr),
        .add_en   (s_r.sum_add),
        .add_byte (s_r.sum_byte),
        .sum      (sum)
    );

    // ======================================================
    // Sequencer
    always_comb
    begin
        logic [19:0] pw_end;
        logic [7:0]  rsum;
        s_nxt          = s_r;
        pw_end         = 20'(s_r.cmp_start + {12'h000, s_r.pwn} - 20'h1);
        rsum           = 8'(s_r.csum + rx_data);
        s_nxt.flash_rd = 1'b0;
        s_nxt.wr_valid = 1'b0;
        s_nxt.sum_clr  = 1'b0;
        s_nxt.sum_add  = 1'b0;
        s_nxt.rd_pend  = s_r.flash_rd;

        // Read engine: one address per clock over one or two ranges
        if (s_r.rd_go)
        begin
            s_nxt.flash_rd   = 1'b1;
            s_nxt.flash_addr = s_r.addr;
            s_nxt.addr       = 20'(s_r.addr + 20'h1);
            if (s_r.addr == s_r.end_addr)
            begin
                if (s_r.second)
                begin
                    s_nxt.second   = 1'b0;
                    s_nxt.addr     = `SBCP_FL_HI_LO;
                    s_nxt.end_addr = `SBCP_FL_HI_HI;
                end
                else
                    s_nxt.rd_go = 1'b0;
            end
        end

        case (s_r.st)
            SBCP_S_IDLE:
            begin
                if (start)
                begin
                    s_nxt.mode    = mode;
                    s_nxt.sum_clr = 1'b1;
                    s_nxt.done    = 1'b0;
                    s_nxt.bcnt    = 2'h0;
                    s_nxt.idx     = 5'h00;
                    s_nxt.ext     = 16'h0000;
                    s_nxt.blank   = 1'b1;
                    s_nxt.er_load = (mode == SBCP_M_ERASE);
                    if (mode == SBCP_M_SUM)
                    begin
                        s_nxt.st       = SBCP_S_FSUM;
                        s_nxt.rd_go    = 1'b1;
                        s_nxt.second   = 1'b1;
                        s_nxt.addr     = `SBCP_FL_LO_LO;
                        s_nxt.end_addr = `SBCP_FL_LO_HI;
                    end
                    else if (mode == SBCP_M_ID || mode == SBCP_M_STATUS)
                        s_nxt.st = SBCP_S_FRAME;
                    else
                    begin
                        // Blank test reads the top bytes before any address arrives
                        s_nxt.st       = SBCP_S_SCAN;
                        s_nxt.rd_go    = 1'b1;
                        s_nxt.second   = 1'b0;
                        s_nxt.addr     = `SBCP_BLANK_LO;
                        s_nxt.end_addr = `SBCP_FL_HI_HI;
                    end
                end
            end

            SBCP_S_SCAN:
            begin
                if (s_r.rd_pend && flash_rdata != `SBCP_BLANK_BYTE)
                    s_nxt.blank = 1'b0;
                if (!s_r.rd_go && !s_r.flash_rd && !s_r.rd_pend)
                    s_nxt.st = SBCP_S_CNTA;
            end

            SBCP_S_CNTA, SBCP_S_CMPA:
            begin
                if (rx_valid)
                begin
                    s_nxt.bcnt = 2'(s_r.bcnt + 2'h1);
                    if (s_r.st == SBCP_S_CNTA)
                        s_nxt.cnt_addr = {s_r.cnt_addr[11:0], rx_data};
                    else
                        s_nxt.cmp_start = {s_r.cmp_start[11:0], rx_data};
                    if (s_r.bcnt == 2'h2 && s_r.st == SBCP_S_CNTA)
                    begin
                        s_nxt.bcnt = 2'h0;
                        s_nxt.st   = SBCP_S_CMPA;
                        if (!in_main({s_r.cnt_addr[11:0], rx_data}))
                            s_nxt.st = SBCP_S_HALT;
                    end
                    else if (s_r.bcnt == 2'h2)
                    begin
                        s_nxt.bcnt = 2'h0;
                        if (!in_main({s_r.cmp_start[11:0], rx_data}))
                            s_nxt.st = SBCP_S_HALT;
                        else if (!s_r.blank)
                        begin
                            s_nxt.st       = SBCP_S_CNT;
                            s_nxt.rd_go    = 1'b1;
                            s_nxt.second   = 1'b0;
                            s_nxt.addr     = s_r.cnt_addr;
                            s_nxt.end_addr = s_r.cnt_addr;
                        end
                        else if (s_r.mode == SBCP_M_ERASE)
                            s_nxt.st = SBCP_S_FSUM;
                        else
                        begin
                            s_nxt.st = SBCP_S_WAIT;
                        end
                    end
                end
            end

            SBCP_S_CNT:
            begin
                // Count arrives, then the first stored byte is fetched
                if (s_r.rd_pend)
                begin
                    s_nxt.pwn = flash_rdata;
                    s_nxt.pwi = 8'h00;
                    s_nxt.run = 2'h0;
                    if (flash_rdata < `SBCP_PW_MIN)
                        s_nxt.st = SBCP_S_HALT;
                    else if (s_r.cmp_start > 20'(`SBCP_PW_LIMIT - {12'h000, flash_rdata}))
                        s_nxt.st = SBCP_S_HALT;
                    else
                    begin
                        s_nxt.st         = SBCP_S_PW;
                        s_nxt.flash_rd   = 1'b1;
                        s_nxt.flash_addr = s_r.cmp_start;
                    end
                end
            end

            SBCP_S_PW:
            begin
                // Stored range may not touch the reserved top block
                if (s_r.cmp_start <= `SBCP_PW_TOP_HI && pw_end >= `SBCP_PW_TOP_LO)
                    s_nxt.st = SBCP_S_HALT;
                else if (rx_valid)
                begin
                    s_nxt.pwi  = 8'(s_r.pwi + 8'h01);
                    s_nxt.prev = rx_data;
                    s_nxt.run  = (s_r.pwi != 8'h00 && rx_data == s_r.prev)
                               ? 2'(s_r.run + 2'h1) : 2'h1;
                    s_nxt.flash_rd   = 1'b1;
                    s_nxt.flash_addr = 20'(s_r.flash_addr + 20'h1);
                    if (rx_data != flash_rdata)
                        s_nxt.st = SBCP_S_HALT;
                    else if (s_nxt.run == `SBCP_RUN_MAX)
                        s_nxt.st = SBCP_S_HALT;
                    else if (8'(s_r.pwi + 8'h01) == s_r.pwn)
                    begin
                        s_nxt.flash_rd = 1'b0;
                        s_nxt.st = (s_r.mode == SBCP_M_ERASE) ? SBCP_S_FSUM : SBCP_S_WAIT;
                    end
                end
            end

            SBCP_S_WAIT:
            begin
                // Everything but the start mark is dropped here
                if (rx_valid && rx_data == `SBCP_START_MARK)
                begin
                    s_nxt.st   = SBCP_S_REC;
                    s_nxt.fld  = SBCP_F_LEN;
                    s_nxt.csum = 8'h00;
                    s_nxt.cnt  = 8'h00;
                end
            end

            SBCP_S_REC:
            begin
                if (rx_valid)
                begin
                    s_nxt.csum = rsum;
                    case (s_r.fld)
                        SBCP_F_LEN:
                        begin
                            s_nxt.len = rx_data;
                            s_nxt.fld = SBCP_F_AH;
                        end
                        SBCP_F_AH:
                        begin
                            s_nxt.raddr = {rx_data, 8'h00};
                            s_nxt.fld   = SBCP_F_AL;
                        end
                        SBCP_F_AL:
                        begin
                            s_nxt.raddr = {s_r.raddr[15:8], rx_data};
                            s_nxt.fld   = SBCP_F_TYP;
                        end
                        SBCP_F_TYP:
                        begin
                            s_nxt.rtype = rx_data;
                            s_nxt.fld   = (s_r.len == 8'h00) ? SBCP_F_CSM : SBCP_F_DAT;
                            if (rx_data > `SBCP_REC_EXT)
                                s_nxt.st = SBCP_S_HALT;
                            else if (rx_data == `SBCP_REC_EXT && s_r.len != `SBCP_EXT_LEN)
                                s_nxt.st = SBCP_S_HALT;
                            else if (rx_data == `SBCP_REC_END && s_r.len != `SBCP_END_LEN)
                                s_nxt.st = SBCP_S_HALT;
                            else if (rx_data == `SBCP_REC_DATA && s_r.ext >= `SBCP_EXT_MAX)
                                s_nxt.st = SBCP_S_HALT;
                        end
                        SBCP_F_DAT:
                        begin
                            s_nxt.cnt = 8'(s_r.cnt + 8'h01);
                            if (8'(s_r.cnt + 8'h01) == s_r.len)
                                s_nxt.fld = SBCP_F_CSM;
                            if (s_r.rtype == `SBCP_REC_EXT)
                                s_nxt.ext = {s_r.ext[7:0], rx_data};
                            else
                            begin
                                // Payload only; header fields never reach the sum
                                s_nxt.wr_valid = 1'b1;
                                s_nxt.wr_data  = rx_data;
                                s_nxt.wr_addr  = 20'({s_r.ext, 4'h0}
                                               + {4'h0, s_r.raddr} + {12'h000, s_r.cnt});
                                s_nxt.sum_add  = (s_r.mode == SBCP_M_RAM);
                                s_nxt.sum_byte = rx_data;
                            end
                        end
                        default:
                        begin
                            if (rsum != 8'h00)
                                s_nxt.st = SBCP_S_HALT;
                            else if (s_r.rtype != `SBCP_REC_END)
                                s_nxt.st = SBCP_S_WAIT;
                            else if (s_r.mode == SBCP_M_RAM)
                                s_nxt.st = SBCP_S_DONE;
                            else
                            begin
                                s_nxt.st       = SBCP_S_FSUM;
                                s_nxt.rd_go    = 1'b1;
                                s_nxt.second   = 1'b1;
                                s_nxt.addr     = `SBCP_FL_LO_LO;
                                s_nxt.end_addr = `SBCP_FL_LO_HI;
                            end
                        end
                    endcase
                end
            end

            SBCP_S_FSUM:
            begin
                // Erase loads its own range once; a flag marks this because a
                // chip erase scan ends with the address wrapped to zero
                if (!s_r.rd_go && !s_r.flash_rd && !s_r.rd_pend && s_r.er_load)
                begin
                    s_nxt.er_load  = 1'b0;
                    s_nxt.rd_go    = 1'b1;
                    s_nxt.second   = erase_chip;
                    s_nxt.addr     = erase_chip ? `SBCP_FL_LO_LO : erase_lo;
                    s_nxt.end_addr = erase_chip ? `SBCP_FL_LO_HI : erase_hi;
                end
                else if (!s_r.rd_go && !s_r.flash_rd && !s_r.rd_pend)
                    s_nxt.st = SBCP_S_DONE;
                if (s_r.rd_pend)
                begin
                    s_nxt.sum_add  = 1'b1;
                    s_nxt.sum_byte = flash_rdata;
                end
            end

            SBCP_S_FRAME:
            begin
                if (tx_valid)
                begin
                    s_nxt.idx      = 5'(s_r.idx + 5'h01);
                    s_nxt.sum_byte = tx_data;
                    s_nxt.sum_add  = (5'(s_r.idx + 5'h01) >= `SBCP_FRM_FIRST);
                    if (5'(s_r.idx + 5'h01) == ((s_r.mode == SBCP_M_ID) ? `SBCP_ID_LAST
                                                                     : `SBCP_ST_LAST))
                        s_nxt.st = SBCP_S_DONE;
                end
            end

            SBCP_S_DONE:
            begin
                // Hold off the flag until the last add has landed
                if (!s_r.sum_add)
                begin
                    s_nxt.done = 1'b1;
                    s_nxt.st   = SBCP_S_IDLE;
                end
            end

            default:
            begin
                // Halt: silent, left only by reset
                s_nxt.halted = 1'b1;
                s_nxt.rd_go  = 1'b0;
            end
        endcase

        // A receive error anywhere in the receiving phases stops the link
        if (rx_error && (s_r.st == SBCP_S_CNTA || s_r.st == SBCP_S_CMPA
            || s_r.st == SBCP_S_PW || s_r.st == SBCP_S_WAIT || s_r.st == SBCP_S_REC))
            s_nxt.st = SBCP_S_HALT;
        if (s_nxt.st == SBCP_S_HALT)
        begin
            s_nxt.wr_valid = 1'b0;
            s_nxt.flash_rd = 1'b0;
            s_nxt.rd_go    = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_r     <= '0;
            s_r.st  <= SBCP_S_IDLE;
            s_r.fld <= SBCP_F_LEN;
        end
        else
            s_r <= s_nxt;
    end

    // ======================================================
    // Outputs, all from the state register
    assign flash_rd   = s_r.flash_rd;
    assign flash_addr = s_r.flash_addr;
    assign wr_valid   = s_r.wr_valid;
    assign wr_addr    = s_r.wr_addr;
    assign wr_data    = s_r.wr_data;
    assign sum_done   = s_r.done;
    assign blank      = s_r.blank;
    assign halted     = s_r.halted;

endmodule : sbcp_boot

// [sbcp_regs.svh]
// Constants for the serial boot checksum and password block.
// Assumes 20-bit flash byte addresses and 8-bit serial bytes.
`ifndef SBCP_REGS_SVH
`define SBCP_REGS_SVH

// ==========================================================
// Flash areas
`define SBCP_FL_LO_LO    20'h04000
`define SBCP_FL_LO_HI    20'h21EFF
`define SBCP_FL_HI_LO    20'hFFF00
`define SBCP_FL_HI_HI    20'hFFFFF
`define SBCP_BLANK_LO    20'hFFFE0
`define SBCP_PW_LIMIT    20'h21F00
`define SBCP_PW_TOP_LO   20'h0FFA0
`define SBCP_PW_TOP_HI   20'h0FFFF

// ==========================================================
// Byte values and limits
`define SBCP_START_MARK  8'h3A
`define SBCP_BLANK_BYTE  8'hFF
`define SBCP_REC_DATA    8'h00
`define SBCP_REC_END     8'h01
`define SBCP_REC_EXT     8'h02
`define SBCP_EXT_LEN     8'h02
`define SBCP_END_LEN     8'h00
`define SBCP_EXT_MAX     16'h1000
`define SBCP_PW_MIN      8'h08
`define SBCP_RUN_MAX     2'h3

// ==========================================================
// Frame byte positions covered by the appended checksum
`define SBCP_FRM_FIRST   5'h09
`define SBCP_ID_LAST     5'h12
`define SBCP_ST_LAST     5'h0C

`endif

// [sbcp_pkg.sv]
// Types for the serial boot checksum and password block.
// Constants live in sbcp_regs.svh; this package holds types only.
package sbcp_pkg;

    // ======================================================
    // Operating modes
    typedef enum logic [2:0] {
        SBCP_M_WRITE  = 3'h0,
        SBCP_M_RAM    = 3'h1,
        SBCP_M_SUM    = 3'h2,
        SBCP_M_ID     = 3'h3,
        SBCP_M_STATUS = 3'h4,
        SBCP_M_ERASE  = 3'h5
    } sbcp_mode_t;

    // ======================================================
    // Main sequencer states
    typedef enum logic [11:0] {
        SBCP_S_IDLE  = 12'h001,
        SBCP_S_SCAN  = 12'h002,
        SBCP_S_CNTA  = 12'h004,
        SBCP_S_CMPA  = 12'h008,
        SBCP_S_CNT   = 12'h010,
        SBCP_S_PW    = 12'h020,
        SBCP_S_WAIT  = 12'h040,
        SBCP_S_REC   = 12'h080,
        SBCP_S_FSUM  = 12'h100,
        SBCP_S_FRAME = 12'h200,
        SBCP_S_DONE  = 12'h400,
        SBCP_S_HALT  = 12'h800
    } sbcp_state_t;

    // ======================================================
    // Hex record field being received
    typedef enum logic [5:0] {
        SBCP_F_LEN = 6'h01,
        SBCP_F_AH  = 6'h02,
        SBCP_F_AL  = 6'h04,
        SBCP_F_TYP = 6'h08,
        SBCP_F_DAT = 6'h10,
        SBCP_F_CSM = 6'h20
    } sbcp_field_t;

endpackage : sbcp_pkg

// [sbcp_sum_acc.sv]
// 16-bit byte-sum accumulator.
// Assumes clear and add are never asked in the same cycle.
`timescale 1ns/100ps
module sbcp_sum_acc
    import sbcp_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic        add_en,
    input  wire logic [7:0]  add_byte,
    output logic      [15:0] sum
);

    typedef struct packed {
        logic [15:0] acc;
    } sbcp_acc_t;

    sbcp_acc_t a_r;
    sbcp_acc_t a_nxt;

    // ======================================================
    // Add one byte at a time, carries past bit 15 dropped
    always_comb
    begin
        a_nxt = a_r;
        if (clear)
            a_nxt.acc = 16'h0000;
        else if (add_en)
            a_nxt.acc = 16'(a_r.acc + {8'h00, add_byte});
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            a_r <= '0;
        else
            a_r <= a_nxt;
    end

    assign sum = a_r.acc;

endmodule : sbcp_sum_acc

// [sbcp_boot_props.sv]
// Port checker for sbcp_boot.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module sbcp_boot_props (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        start,
    input wire sbcp_pkg::sbcp_mode_t mode,
    input wire logic        rx_valid,
    input wire logic        rx_error,
    input wire logic        flash_rd,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0]  flash_rdata,
    input wire logic        wr_valid,
    input wire logic [7:0]  wr_data,
    input wire logic [15:0] sum,
    input wire logic        sum_done,
    input wire logic        halted
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ========
    // Halt and sum relations
    property p_h1; halted |=> halted; endproperty
    a_h1: assert property (p_h1) else $error("halt lost");
    property p_h2; halted |-> !wr_valid && !flash_rd; endproperty
    a_h2: assert property (p_h2) else $error("busy in halt");
    property p_h3; $rose(halted) |-> $past(rx_valid, 2) || $past(rx_error, 2)
        || $past(flash_rd, 2) || $past(flash_rd, 3); endproperty
    a_h3: assert property (p_h3) else $error("halt cause");
    // Only the RAM loader sums payload; write mode sums flash later
    property p_s1; wr_valid && mode == sbcp_pkg::SBCP_M_RAM |=>
        sum == 16'($past(sum) + $past(wr_data)); endproperty
    a_s1: assert property (p_s1) else $error("payload sum");
    property p_s2; wr_valid |-> $past(rx_valid) || $past(rx_valid, 2); endproperty
    a_s2: assert property (p_s2) else $error("write cause");
    property p_s3; wr_valid |=> !wr_valid; endproperty
    a_s3: assert property (p_s3) else $error("write pulse");
    property p_s4; sum_done && !start |=> sum_done && $stable(sum); endproperty
    a_s4: assert property (p_s4) else $error("sum moved");
    property p_s5; flash_rd && $past(flash_rd) |->
        flash_addr == $past(flash_addr) + 20'h1 || flash_addr == 20'hFFF00; endproperty
    a_s5: assert property (p_s5) else $error("scan order");
    c_h: cover property ($rose(halted));
    c_w: cover property (wr_valid);
    c_d: cover property ($rose(sum_done));
endmodule : sbcp_boot_props
bind sbcp_boot sbcp_boot_props u_props (.*);

// [sbcp_flash_model.sv]
// Flash array behind the read port of sbcp_boot, blank only in its top bytes; lower bytes read as their address low byte.
// Assumes data is wanted one clock after flash_rd, held until the next.
`timescale 1ns/100ps
module sbcp_flash_model (
    input  wire logic        clock,
    input  wire logic        flash_rd,
    input  wire logic [19:0] flash_addr,
    output logic      [7:0]  flash_rdata = '0
);
    // Top bytes all FFH so the part reads as blank
    always @(posedge clock)
    begin
        if (flash_rd)
            flash_rdata <= flash_addr >= 20'hFFFE0 ? 8'hFF : flash_addr[7:0];
    end
endmodule : sbcp_flash_model

// [sbcp_boot_tb_top.sv]
// Bench for sbcp_boot: frame sums, RAM records, record errors.
// Assumes the blank flash model on the read port.
`timescale 1ns/100ps
module sbcp_boot_tb_top;
    import sbcp_pkg::*;
    logic         clock = 0, rst_n = 0, start = 0, rx_valid = 0, rx_error = 0, tx_valid = 0;
    logic [7:0]   rx_data = 0, tx_data = 0, flash_rdata, wr_data, d0, d1;
    sbcp_mode_t   mode = SBCP_M_RAM;
    logic         flash_rd, wr_valid, sum_done, blank, halted, done_q = 0, erase_chip = 0;
    logic [19:0]  flash_addr, wr_addr, erase_lo = 20'h04000, erase_hi = 20'h04000;
    logic [15:0]  sum, exp_s;
    logic [31:0]  seed = 32'hF2FAFC88;
    logic [27:0]  qw[$];
    logic [15:0]  qs[$];
    int           err_count = 0, compares = 0, len[5] = '{6, 6, 7, 7, 13};
    logic [103:0] bad[5] = '{104'h3A00000003FD, 104'h3A0000000100, 104'h3A0100000210ED,
                             104'h3A0100000100FE, 104'h3A020000021000EC3A01000000};
    always #50 clock = ~clock;
    sbcp_boot DUT (.*);
    sbcp_flash_model u_flash (.*);
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic results();
        if (err_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input logic [27:0] e, s, input string n);
        compares++;
        if (e !== s)
        begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // One byte on rx or tx, spaced three clocks
    task automatic put(input logic [7:0] b, input bit r);
        @(negedge clock);
        rx_data = b;
        tx_data = b;
        rx_valid = r;
        tx_valid = !r;
        @(negedge clock);
        rx_valid = 0;
        tx_valid = 0;
        @(negedge clock);
    endtask : put
    task automatic seq(input logic [119:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            put(v[8*i+:8], 1'b1);
    endtask : seq
    task automatic go(input sbcp_mode_t m);
        rst_n = 0;
        repeat (8) @(negedge clock);
        chk(0, {halted, sum_done, wr_valid, flash_rd, sum}, "reset");
        rst_n = 1;
        mode = m;
        start = 1;
        @(negedge clock);
        start = 0;
    endtask : go
    task automatic wt(input bit b);
        int k = 0;
        // Blank test: the scan of the top bytes takes about 35 clocks
        if (b)
        begin
            repeat (40) @(negedge clock);
            chk(1, blank, "blank");
        end
        while (!b && sum_done !== 1'b1 && k < 300)
        begin
            @(negedge clock);
            k++;
        end
        if (k == 300)
        begin
            err_count++;
            results();
        end
    endtask : wt
    // Results are taken against the oldest note
    always @(negedge clock)
    begin
        done_q <= sum_done;
        if (wr_valid)
            chk(qw.size() > 0 ? qw.pop_front() : 'x, {wr_addr, wr_data}, "write");
        if (sum_done && !done_q)
            chk(qs.size() > 0 ? qs.pop_front() : 'x, 28'(sum), "sum");
    end
    // ========
    // Main sequence
    initial
    begin
        for (int m = 3; m <= 4; m++)
        begin
            go(sbcp_mode_t'(m));
            exp_s = 0;
            for (int i = 1; i <= (m == 3 ? 18 : 12); i++)
            begin
                d0 = rnd();
                exp_s += i >= 9 ? 16'(d0) : 16'h0;
                if (i == (m == 3 ? 18 : 12))
                    qs.push_back(exp_s);
                put(d0, 1'b0);
            end
            wt(1'b0);
        end
        go(SBCP_M_RAM);
        wt(1'b1);
        d0 = rnd();
        d1 = rnd();
        qw.push_back({20'h00010, d0});
        qw.push_back({20'h00011, d1});
        qs.push_back(16'(d0) + 16'(d1));
        seq(56'h00400000400111, 7);
        seq({40'h3A02001000, d0, d1, 8'hEE - d0 - d1, 56'h773A00000001FF}, 15);
        wt(1'b0);
        // Blank sector erase: both addresses, no password, then the area sum
        go(SBCP_M_ERASE);
        wt(1'b1);
        erase_lo = 20'h04000 + 20'(rnd());
        erase_hi = 20'(erase_lo + 20'h0000F);
        exp_s = 0;
        for (int a = 0; a < 16; a++)
            exp_s += 16'(8'(erase_lo + 20'(a)));
        qs.push_back(exp_s);
        seq(48'h004000004001, 6);
        wt(1'b0);
        for (int e = 0; e < 5; e++)
        begin
            go(e % 2 ? SBCP_M_WRITE : SBCP_M_RAM);
            wt(1'b1);
            seq(48'h004000004001, 6);
            seq(bad[e], len[e]);
            repeat (4) @(negedge clock);
            chk(1, halted, "halt");
        end
        chk(0, qs.size() + qw.size(), "left");
        results();
    end
endmodule : sbcp_boot_tb_top
